// ### rtl/bcis_pkg.sv
// Constants shared by the bridge identification and status register bank
package bcis_pkg;

  // Configuration access geometry
  localparam int unsigned BCIS_ADDR_W = 12;
  localparam int unsigned BCIS_DATA_W = 32;
  localparam int unsigned BCIS_BE_W = 4;
  localparam int unsigned BCIS_CODE_W = 16;

  // Register byte offsets
  localparam logic [BCIS_ADDR_W-1:0] BCIS_OFF_IDENT = 12'h000;
  localparam logic [BCIS_ADDR_W-1:0] BCIS_OFF_CSR = 12'h004;

  // Identification register field layout
  localparam int unsigned BCIS_DEV_MSB = 31;
  localparam int unsigned BCIS_DEV_LSB = 16;
  localparam int unsigned BCIS_VEN_MSB = 15;
  localparam int unsigned BCIS_VEN_LSB = 0;

  // Command and status register bit positions
  localparam int unsigned BCIS_BIT_POISON = 31;
  localparam int unsigned BCIS_BIT_SYSERR = 30;
  localparam int unsigned BCIS_BIT_UNSUP = 29;
  localparam int unsigned BCIS_BIT_CAPLIST = 20;
  localparam int unsigned BCIS_BIT_SYS_RPT_EN = 8;
  localparam int unsigned BCIS_BIT_PAR_RESP_EN = 6;

  // Byte lanes that carry the writable fields
  localparam int unsigned BCIS_LANE_FLAGS = 3;
  localparam int unsigned BCIS_LANE_SYS_RPT_EN = 1;
  localparam int unsigned BCIS_LANE_PAR_RESP_EN = 0;

  // Command and status register reset image
  localparam logic [BCIS_DATA_W-1:0] BCIS_CSR_RESET = 32'h0010_0000;

  // Sticky flag indices inside the flag keeper
  localparam int unsigned BCIS_NUM_FLAGS = 3;
  localparam int unsigned BCIS_FLG_POISON = 0;
  localparam int unsigned BCIS_FLG_SYSERR = 1;
  localparam int unsigned BCIS_FLG_UNSUP = 2;

endpackage

// ### rtl/bcis_flag_if.sv
// Set, clear and state lines between the register bank and its flag keeper
`timescale 1ns/100ps
interface bcis_flag_if #(
  parameter int N = 3
);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] flags;

  modport keeper (input set, input clr, output flags);
  modport user (output set, output clr, input flags);
endinterface

// ### rtl/bcis_w1c_flags.sv
// Sticky write-one-to-clear flag keeper
`timescale 1ns/100ps
module bcis_w1c_flags #(
  parameter int N = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Flag set and clear lines
  bcis_flag_if.keeper fl
);

  logic [N-1:0] flags_q;
  logic [N-1:0] flags_d;

  // Set is ORed in after the clear so a same-cycle event is never lost
  assign flags_d = (flags_q & ~fl.clr) | fl.set;

  // Flags start cleared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign fl.flags = flags_q;

endmodule

// ### rtl/bcis_top.sv
// Bridge identification register and upper error-status flags of command and status
//
// Function
// - Identification reads device code in 31:16 and vendor code in 15:0, software writes ignored.
// - Device and vendor codes take EEPROM replacements, else keep their built-in defaults.
// - Bit 31 sets on a poisoned packet or bad-ECRC read completion or write request, ignoring parity response enable.
// - Bit 30 sets only when an ERR_FATAL or ERR_NONFATAL message is sent with system error report enabled.
// - Bit 29 sets when a completion with Unsupported Request status is received.
// - The three flags reset to zero, read one only after their event, and clear on a written one.
`timescale 1ns/100ps
module bcis_top
  import bcis_pkg::*;
#(
  parameter logic [BCIS_CODE_W-1:0] DEFAULT_DEVICE_CODE = 16'h0A5A, // Arbitrary value
  parameter logic [BCIS_CODE_W-1:0] DEFAULT_VENDOR_CODE = 16'h1234 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration access from the PCIe side
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [BCIS_ADDR_W-1:0] cfg_addr,
  input wire logic [BCIS_BE_W-1:0] cfg_byte_en,
  input wire logic [BCIS_DATA_W-1:0] cfg_wdata,
  output logic cfg_done,
  output logic [BCIS_DATA_W-1:0] cfg_rdata,
  // Code replacement from the EEPROM loader
  input wire logic code_load,
  input wire logic [BCIS_CODE_W-1:0] code_load_device,
  input wire logic [BCIS_CODE_W-1:0] code_load_vendor,
  // Error events from the PCIe interface
  input wire logic evt_poisoned_rx,
  input wire logic evt_bad_ecrc_rx,
  input wire logic evt_err_msg_tx,
  input wire logic evt_ur_cpl_rx,
  // Command bits toward the rest of the bridge
  output logic parity_response_enable,
  output logic system_error_report_enable
);

  // Address decode of a dword-aligned byte offset
  function automatic logic addr_hit(input logic [BCIS_ADDR_W-1:0] addr,
                                    input logic [BCIS_ADDR_W-1:0] off);
    addr_hit = (addr[BCIS_ADDR_W-1:2] == off[BCIS_ADDR_W-1:2]);
  endfunction

  logic [BCIS_CODE_W-1:0] device_code_q;
  logic [BCIS_CODE_W-1:0] vendor_code_q;
  logic parity_response_enable_q;
  logic system_error_report_enable_q;
  logic cfg_done_q;
  logic [BCIS_DATA_W-1:0] cfg_rdata_q;
  logic [BCIS_DATA_W-1:0] rdata_d;
  logic [BCIS_DATA_W-1:0] ident_word;
  logic [BCIS_DATA_W-1:0] csr_word;
  logic hit_ident;
  logic hit_csr;
  logic csr_wr;
  logic flag_lane_wr;
  logic set_poison;
  logic set_syserr;
  logic set_unsup;
  logic detected_poison_flag;
  logic signaled_sys_error_flag;
  logic received_unsupported_flag;

  bcis_flag_if #(.N(BCIS_NUM_FLAGS)) flag_bus ();

  // Request decode
  assign hit_ident = addr_hit(cfg_addr, BCIS_OFF_IDENT);
  assign hit_csr = addr_hit(cfg_addr, BCIS_OFF_CSR);
  assign csr_wr = cfg_valid && cfg_write && hit_csr;
  assign flag_lane_wr = csr_wr && cfg_byte_en[BCIS_LANE_FLAGS];

  // Event qualification; bad ECRC is only reported by the link for read completions
  // and write requests, so no type filter is repeated here
  assign set_poison = evt_poisoned_rx || evt_bad_ecrc_rx;
  assign set_syserr = evt_err_msg_tx && system_error_report_enable_q;
  assign set_unsup = evt_ur_cpl_rx;

  // Flag keeper set and clear lines; only a written one on the status lane clears
  assign flag_bus.set[BCIS_FLG_POISON] = set_poison;
  assign flag_bus.set[BCIS_FLG_SYSERR] = set_syserr;
  assign flag_bus.set[BCIS_FLG_UNSUP] = set_unsup;
  assign flag_bus.clr[BCIS_FLG_POISON] = flag_lane_wr && cfg_wdata[BCIS_BIT_POISON];
  assign flag_bus.clr[BCIS_FLG_SYSERR] = flag_lane_wr && cfg_wdata[BCIS_BIT_SYSERR];
  assign flag_bus.clr[BCIS_FLG_UNSUP] = flag_lane_wr && cfg_wdata[BCIS_BIT_UNSUP];

  bcis_w1c_flags #(.N(BCIS_NUM_FLAGS)) u_flags (
    .clk(clk),
    .rst(rst),
    .fl(flag_bus.keeper)
  );

  assign detected_poison_flag = flag_bus.flags[BCIS_FLG_POISON];
  assign signaled_sys_error_flag = flag_bus.flags[BCIS_FLG_SYSERR];
  assign received_unsupported_flag = flag_bus.flags[BCIS_FLG_UNSUP];

  // Identification codes; the config path has no write port into them at all
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      device_code_q <= DEFAULT_DEVICE_CODE;
      vendor_code_q <= DEFAULT_VENDOR_CODE;
    end else if (code_load) begin
      device_code_q <= code_load_device;
      vendor_code_q <= code_load_vendor;
    end
  end

  // Command enables, each updated only when its byte lane is enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parity_response_enable_q <= BCIS_CSR_RESET[BCIS_BIT_PAR_RESP_EN];
      system_error_report_enable_q <= BCIS_CSR_RESET[BCIS_BIT_SYS_RPT_EN];
    end else if (csr_wr) begin
      if (cfg_byte_en[BCIS_LANE_PAR_RESP_EN]) begin
        parity_response_enable_q <= cfg_wdata[BCIS_BIT_PAR_RESP_EN];
      end
      if (cfg_byte_en[BCIS_LANE_SYS_RPT_EN]) begin
        system_error_report_enable_q <= cfg_wdata[BCIS_BIT_SYS_RPT_EN];
      end
    end
  end

  // Read images; unimplemented status and command bits read as zero
  always_comb begin
    ident_word = '0;
    ident_word[BCIS_DEV_MSB:BCIS_DEV_LSB] = device_code_q;
    ident_word[BCIS_VEN_MSB:BCIS_VEN_LSB] = vendor_code_q;
  end

  always_comb begin
    csr_word = '0;
    csr_word[BCIS_BIT_CAPLIST] = BCIS_CSR_RESET[BCIS_BIT_CAPLIST];
    csr_word[BCIS_BIT_POISON] = detected_poison_flag;
    csr_word[BCIS_BIT_SYSERR] = signaled_sys_error_flag;
    csr_word[BCIS_BIT_UNSUP] = received_unsupported_flag;
    csr_word[BCIS_BIT_SYS_RPT_EN] = system_error_report_enable_q;
    csr_word[BCIS_BIT_PAR_RESP_EN] = parity_response_enable_q;
  end

  // Read select; unmapped offsets answer zero so a stray probe never hangs
  assign rdata_d = (!cfg_valid || cfg_write) ? '0 :
                   hit_ident ? ident_word :
                   hit_csr ? csr_word : '0;

  // Every request is answered one cycle later, reads and writes alike
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_done_q <= 1'b0;
      cfg_rdata_q <= '0;
    end else begin
      cfg_done_q <= cfg_valid;
      cfg_rdata_q <= rdata_d;
    end
  end

  assign cfg_done = cfg_done_q;
  assign cfg_rdata = cfg_rdata_q;
  assign parity_response_enable = parity_response_enable_q;
  assign system_error_report_enable = system_error_report_enable_q;

  // Named steps of the register accesses and the system error report
  sequence seq_ident_read;
    cfg_valid && !cfg_write && hit_ident;
  endsequence

  sequence seq_poison_clear;
    flag_lane_wr && cfg_wdata[BCIS_BIT_POISON] && !set_poison;
  endsequence

  sequence seq_unsup_zero_write;
    flag_lane_wr && !cfg_wdata[BCIS_BIT_UNSUP];
  endsequence

  sequence seq_syserr_report;
    evt_err_msg_tx && system_error_report_enable_q;
  endsequence

  // Checks next to the logic
  AST_ID_READBACK: assert property (@(posedge clk) disable iff (rst)
    seq_ident_read ##1 1'b1 |-> cfg_done &&
      cfg_rdata == {$past(device_code_q), $past(vendor_code_q)})
    else $error("identification read returned wrong image");

  AST_ID_WRITE_IGNORED: assert property (@(posedge clk) disable iff (rst)
    cfg_valid && cfg_write && hit_ident && !code_load |=>
      $stable(device_code_q) && $stable(vendor_code_q))
    else $error("identification changed by a software write");

  AST_CODE_LOAD: assert property (@(posedge clk) disable iff (rst)
    code_load |=> device_code_q == $past(code_load_device) &&
      vendor_code_q == $past(code_load_vendor))
    else $error("EEPROM code replacement not taken");

  AST_POISON_SET: assert property (@(posedge clk) disable iff (rst)
    evt_poisoned_rx || evt_bad_ecrc_rx |=> detected_poison_flag)
    else $error("poison flag not set after poisoned or bad ECRC packet");

  AST_SYSERR_SET: assert property (@(posedge clk) disable iff (rst)
    seq_syserr_report |=> signaled_sys_error_flag)
    else $error("system error flag not set after reported message");

  AST_SYSERR_GATED: assert property (@(posedge clk) disable iff (rst)
    $rose(signaled_sys_error_flag) |-> $past(evt_err_msg_tx && system_error_report_enable_q))
    else $error("system error flag set without enabled message");

  AST_UNSUP_SET: assert property (@(posedge clk) disable iff (rst)
    evt_ur_cpl_rx |=> received_unsupported_flag && csr_word[BCIS_BIT_UNSUP])
    else $error("unsupported completion flag not set");

  AST_POISON_CLEAR: assert property (@(posedge clk) disable iff (rst)
    seq_poison_clear |=> !detected_poison_flag)
    else $error("poison flag not cleared by written one");

  AST_FLAG_FALL_CAUSE: assert property (@(posedge clk) disable iff (rst)
    $fell(received_unsupported_flag) |-> $past(flag_lane_wr && cfg_wdata[BCIS_BIT_UNSUP]))
    else $error("unsupported flag dropped without a clearing write");

  AST_ZERO_WRITE_HOLDS: assert property (@(posedge clk) disable iff (rst)
    received_unsupported_flag ##0 seq_unsup_zero_write |=> received_unsupported_flag)
    else $error("written zero disturbed a status flag");

  AST_SET_BEATS_CLEAR: assert property (@(posedge clk) disable iff (rst)
    flag_lane_wr && cfg_wdata[BCIS_BIT_POISON] && set_poison |=> detected_poison_flag)
    else $error("same-cycle event lost to a clearing write");

endmodule

// ### verif/bcis_rc_model.sv
// Root complex stand-in that issues configuration reads and writes
`timescale 1ns/100ps
module bcis_rc_model
  import bcis_pkg::*;
(
  // Clock
  input wire logic clk,
  // Requests toward the register bank
  output logic cfg_valid,
  output logic cfg_write,
  output logic [BCIS_ADDR_W-1:0] cfg_addr,
  output logic [BCIS_BE_W-1:0] cfg_byte_en,
  output logic [BCIS_DATA_W-1:0] cfg_wdata,
  // Answers from the register bank
  input wire logic cfg_done,
  input wire logic [BCIS_DATA_W-1:0] cfg_rdata
);
  // Quiet bus until the first request
  initial begin
    cfg_valid = 1'b0;
    cfg_write = 1'b0;
    cfg_addr = 12'hFFC;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h0;
  end

  // One request held across its taking edge; idle lines then carry inverted junk
  task automatic xfer(input logic wr, input logic [BCIS_ADDR_W-1:0] a,
      input logic [BCIS_BE_W-1:0] be, input logic [BCIS_DATA_W-1:0] wd,
      output logic done, output logic [BCIS_DATA_W-1:0] rd);
    @(negedge clk);
    cfg_valid = 1'b1;
    cfg_write = wr;
    cfg_addr = a;
    cfg_byte_en = be;
    cfg_wdata = wd;
    @(negedge clk);
    done = cfg_done;
    rd = cfg_rdata;
    cfg_valid = 1'b0;
    cfg_write = ~wr;
    cfg_addr = ~a;
    cfg_byte_en = ~be;
    cfg_wdata = ~wd;
  endtask
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the identification and error-status register bank
`timescale 1ns/100ps
module tb_top;
  import bcis_pkg::*;
  localparam logic [15:0] DEV = 16'h0A5A; // Arbitrary value
  localparam logic [15:0] VEN = 16'h1234; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic code_load = 1'b0;
  logic [15:0] code_load_device = 16'h0;
  logic [15:0] code_load_vendor = 16'h0;
  logic [3:0] evt = 4'h0;
  logic cfg_valid, cfg_write, cfg_done, perr_en, sys_rpt_en, done;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  logic [2:0] exp_fl = 3'b000;
  logic exp_serr = 1'b0;
  logic exp_perr = 1'b0;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  // Free-running core clock, 4 ns
  always #2 clk = ~clk;

  bcis_rc_model i_rc (.clk(clk), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_done(cfg_done), .cfg_rdata(cfg_rdata));

  bcis_top #(.DEFAULT_DEVICE_CODE(DEV), .DEFAULT_VENDOR_CODE(VEN)) i_dut (.clk(clk),
    .rst(rst), .cfg_valid(cfg_valid), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
    .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_done(cfg_done),
    .cfg_rdata(cfg_rdata), .code_load(code_load), .code_load_device(code_load_device),
    .code_load_vendor(code_load_vendor), .evt_poisoned_rx(evt[0]),
    .evt_bad_ecrc_rx(evt[1]), .evt_err_msg_tx(evt[2]), .evt_ur_cpl_rx(evt[3]),
    .parity_response_enable(perr_en), .system_error_report_enable(sys_rpt_en));

  // Closing report, reached from the end of the run or the hang guard
  task give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard: the whole run needs about 150 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Expected status image from the tracked flags and enables
  function automatic logic [31:0] csr_img();
    return BCIS_CSR_RESET | {exp_fl, 29'h0} | (32'(exp_serr) << 8) | (32'(exp_perr) << 6);
  endfunction

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    i_rc.xfer(1'b0, a, 4'hF, 32'h0, done, rd);
    check({what, " done"}, 32'(done), 32'h1);
    check(what, rd, exp);
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    i_rc.xfer(1'b1, a, be, d, done, rd);
    check("write done", 32'(done), 32'h1);
  endtask

  // One-cycle event pulse, launched at a falling edge
  task automatic pulse(input int k);
    @(negedge clk);
    evt[k] = 1'b1;
    @(negedge clk);
    evt = 4'h0;
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd_chk("ident reset", BCIS_OFF_IDENT, {DEV, VEN});
    rd_chk("csr reset", BCIS_OFF_CSR, BCIS_CSR_RESET);
    wr(BCIS_OFF_IDENT, 4'hF, 32'hFFFF_FFFF);
    rd_chk("ident after write", BCIS_OFF_IDENT, {DEV, VEN});
    rd_chk("unmapped read", 12'h008, 32'h0);
    @(negedge clk);
    code_load = 1'b1;
    code_load_device = 16'hC3E1;
    code_load_vendor = 16'h5B07;
    @(negedge clk);
    code_load = 1'b0;
    code_load_device = 16'h3C1E;
    code_load_vendor = 16'hA4F8;
    rd_chk("ident loaded", BCIS_OFF_IDENT, 32'hC3E1_5B07);
    // First pass with both enables off, second with both on
    for (int pass = 0; pass < 2; pass++) begin
      for (int k = 0; k < 4; k++) begin
        pulse(k);
        if (k != 2 || exp_serr)
          exp_fl[(k < 2) ? 2 : 3 - k] = 1'b1;
        rd_chk("flag set", BCIS_OFF_CSR, csr_img());
        wr(BCIS_OFF_CSR, 4'h8, 32'h0);
        wr(BCIS_OFF_CSR, 4'h7, csr_img() | 32'hE000_0000);
        rd_chk("flag after zero write", BCIS_OFF_CSR, csr_img());
        wr(BCIS_OFF_CSR, 4'h8, 32'hE000_0000);
        exp_fl = 3'b000;
        rd_chk("flag cleared", BCIS_OFF_CSR, csr_img());
      end
      wr(BCIS_OFF_CSR, 4'h3, 32'h0000_0140);
      exp_serr = 1'b1;
      exp_perr = 1'b1;
      check("enables", {30'h0, sys_rpt_en, perr_en}, 32'h3);
    end
    // Set and clear in the same cycle on the poison flag: set must win
    pulse(0);
    fork
      wr(BCIS_OFF_CSR, 4'h8, 32'hE000_0000);
      pulse(0);
    join
    exp_fl = 3'b100;
    rd_chk("set beats clear", BCIS_OFF_CSR, csr_img());
    // Second reset mid-run brings everything back
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rd_chk("csr after reset", BCIS_OFF_CSR, BCIS_CSR_RESET);
    rd_chk("ident after reset", BCIS_OFF_IDENT, {DEV, VEN});
    give_verdict();
  end
endmodule
